/* logic/transfer_arith_datapath.sv */
// transfer and single-length arithmetic datapath for an 18-bit word machine
`timescale 1ns/1ns
`default_nettype none
module transfer_arith_datapath
  import transfer_arith_pkg::*;
(
  input wire logic clk,
  input wire logic reset_n,
  input wire logic issue,
  input wire transfer_arith_pkg::instr_t instr,
  input wire transfer_arith_pkg::word_t operand,
  input wire transfer_arith_pkg::word_t index_word,
  output transfer_arith_pkg::mem_write_t write,
  output transfer_arith_pkg::word_t upper_accumulator_word,
  output transfer_arith_pkg::word_t lower_accumulator_word,
  output logic [2:0] index_select_register,
  output logic [3:0] special_register,
  output logic special_active,
  output logic overflow,
  output logic skip,
  output logic done
);
  import transfer_arith_pkg::*;

  // ****************************************
  // helpers
  // ****************************************

  // copy the constant's sign into the upper six bits
  function automatic word_t sign_extend(input logic [CONST_W-1:0] u);
    sign_extend = {{(WORD_W-CONST_W){u[CONST_W-1]}}, u};
  endfunction : sign_extend

  // select value zero has no cell 00, so it lands on cell 10 octal
  function automatic logic [CELL_W-1:0] cell_of(input logic [ICR_W-1:0] sel);
    cell_of = (sel == 3'h0) ? CELL_FOR_ZERO : {3'h0, sel};
  endfunction : cell_of

  // ****************************************
  // decode
  // ****************************************
  logic is_minor;
  logic [5:0] minor;
  logic do_add;
  logic do_sub;
  logic [17:0] arith_sum;
  logic arith_ovf;

  assign minor = instr.u[11:6];
  assign is_minor = (instr.func == F_MINOR_GROUP);
  assign do_add = issue && (instr.func == F_ADD_LOWER || instr.func == F_ADD_LOWER_B);
  assign do_sub = issue && (instr.func == F_SUB_LOWER || instr.func == F_SUB_LOWER_B);

  // one shared 18-bit adder; sub is add of the complement
  ones_adder adder_i (
    .a(lower_accumulator_word),
    .b(operand),
    .subtract(do_sub),
    .sum(arith_sum),
    .overflow(arith_ovf)
  );

  // ****************************************
  // accumulator halves
  // ****************************************

  // a load replaces the whole half, which is the clear-then-transmit effect
  always_ff @(posedge clk) begin
    if (!reset_n) begin
      upper_accumulator_word <= WORD_RESET;
    end else if (issue && (instr.func == F_LOAD_UPPER || instr.func == F_LOAD_UPPER_B)) begin
      upper_accumulator_word <= operand;
    end
  end

  // stores leave this half alone; only loads and arithmetic touch it
  always_ff @(posedge clk) begin
    if (!reset_n) begin
      lower_accumulator_word <= WORD_RESET;
    end else if (issue) begin
      unique case (instr.func)
        F_LOAD_LOWER, F_LOAD_LOWER_B: lower_accumulator_word <= operand;
        F_LOAD_LOWER_CONST: lower_accumulator_word <= sign_extend(instr.u);
        F_ADD_LOWER, F_ADD_LOWER_B: lower_accumulator_word <= arith_sum;
        F_SUB_LOWER, F_SUB_LOWER_B: lower_accumulator_word <= arith_sum;
        default: lower_accumulator_word <= lower_accumulator_word;
      endcase
    end
  end

  // ****************************************
  // index select and special registers
  // ****************************************
  always_ff @(posedge clk) begin
    if (!reset_n) begin
      index_select_register <= 3'h0;
    end else if (issue && is_minor && minor == M_LOAD_INDEX_SELECT) begin
      index_select_register <= instr.u[ICR_W-1:0];
    end
  end

  // storing the special register empties it, which also deactivates it
  always_ff @(posedge clk) begin
    if (!reset_n) begin
      special_register <= 4'h0;
    end else if (issue && is_minor && minor == M_LOAD_SPECIAL) begin
      special_register <= instr.u[SR_W-1:0];
    end else if (issue && instr.func == F_STORE_SPECIAL) begin
      special_register <= 4'h0;
    end
  end

  // active flag mirrors bit 3, kept as its own flop so the output is registered
  always_ff @(posedge clk) begin
    if (!reset_n) begin
      special_active <= 1'b0;
    end else if (issue && is_minor && minor == M_LOAD_SPECIAL) begin
      special_active <= instr.u[SPECIAL_ACTIVE_BIT];
    end else if (issue && instr.func == F_STORE_SPECIAL) begin
      special_active <= 1'b0;
    end
  end

  // ****************************************
  // overflow designator and skip
  // ****************************************
  logic ovf_skip_op;

  assign ovf_skip_op = issue && is_minor &&
                       (minor == M_SKIP_IF_OVERFLOW || minor == M_SKIP_IF_NO_OVERFLOW);

  // sticky; a skip and an arithmetic op cannot share one issue, set still wins
  always_ff @(posedge clk) begin
    if (!reset_n) begin
      overflow <= 1'b0;
    end else if ((do_add || do_sub) && arith_ovf) begin
      overflow <= 1'b1;
    end else if (ovf_skip_op) begin
      overflow <= 1'b0;
    end
  end

  // skip decision reported to the sequencer for the overflow tests
  always_ff @(posedge clk) begin
    if (!reset_n) begin
      skip <= 1'b0;
    end else begin
      skip <= ovf_skip_op && ((minor == M_SKIP_IF_OVERFLOW) ? overflow : !overflow);
    end
  end

  // ****************************************
  // core writes
  // ****************************************
  mem_write_t next_write;

  // effective address for plain stores; index cell when B itself changes
  always_comb begin
    next_write = '0;
    next_write.cell_addr = cell_of(index_select_register);
    if (issue) begin
      unique case (instr.func)
        F_LOAD_INDEX, F_LOAD_INDEX_B: begin
          next_write.en = 1'b1;
          next_write.to_index_cell = 1'b1;
          next_write.data = operand;
        end
        F_LOAD_INDEX_CONST: begin
          next_write.en = 1'b1;
          next_write.to_index_cell = 1'b1;
          next_write.data = sign_extend(instr.u);
        end
        F_ZERO_STORE, F_ZERO_STORE_B: begin
          next_write.en = 1'b1;
          next_write.data = WORD_RESET;
        end
        F_STORE_INDEX, F_STORE_INDEX_B: begin
          next_write.en = 1'b1;
          next_write.data = index_word;
        end
        F_STORE_LOWER, F_STORE_LOWER_B: begin
          next_write.en = 1'b1;
          next_write.data = lower_accumulator_word;
        end
        F_STORE_UPPER, F_STORE_UPPER_B: begin
          next_write.en = 1'b1;
          next_write.data = upper_accumulator_word;
        end
        F_STORE_INDEX_SELECT: begin
          next_write.en = 1'b1;
          next_write.data = {operand[17:6], cell_of(index_select_register)};
        end
        F_STORE_ADDR_FIELD: begin
          next_write.en = 1'b1;
          next_write.data = {operand[17:12], lower_accumulator_word[11:0]};
        end
        F_STORE_SPECIAL: begin
          next_write.en = 1'b1;
          next_write.data = {operand[17:6], 2'b00, special_register};
        end
        default: next_write.en = 1'b0;
      endcase
    end
  end

  always_ff @(posedge clk) begin
    if (!reset_n) begin
      write <= '0;
    end else begin
      write <= next_write;
    end
  end

  // every issue completes in one cycle
  always_ff @(posedge clk) begin
    if (!reset_n) begin
      done <= 1'b0;
    end else begin
      done <= issue;
    end
  end

  // ****************************************
  // checks
  // ****************************************
  default clocking cb @(posedge clk); endclocking
  default disable iff (!reset_n);

  load_upper_a: assert property (
    issue && instr.func == F_LOAD_UPPER |=> upper_accumulator_word == $past(operand))
    else $error("upper load wrong");

  const_lower_a: assert property (
    issue && instr.func == F_LOAD_LOWER_CONST |=>
      lower_accumulator_word == {{6{$past(instr.u[11])}}, $past(instr.u)})
    else $error("lower constant load wrong");

  index_const_a: assert property (
    issue && instr.func == F_LOAD_INDEX_CONST |=>
      write.en && write.to_index_cell && write.data[17:12] == {6{$past(instr.u[11])}})
    else $error("index constant write wrong");

  zero_store_a: assert property (
    issue && instr.func == F_ZERO_STORE |=> write.en && write.data == 18'h00000)
    else $error("zero store wrong");

  store_keep_a: assert property (
    issue && instr.func == F_STORE_LOWER |=>
      write.data == $past(lower_accumulator_word) && $stable(lower_accumulator_word))
    else $error("lower store disturbed accumulator");

  cell_zero_a: assert property (
    issue && instr.func == F_STORE_INDEX_SELECT && index_select_register == 3'h0 |=>
      write.data[5:0] == 6'o10)
    else $error("select zero cell wrong");

  addr_field_a: assert property (
    issue && instr.func == F_STORE_ADDR_FIELD |=>
      write.data[17:12] == $past(operand[17:12]) &&
      write.data[11:0] == $past(lower_accumulator_word[11:0]))
    else $error("address field store wrong");

  special_clear_a: assert property (
    issue && instr.func == F_STORE_SPECIAL |=>
      write.data[5:4] == 2'b00 && special_register == 4'h0 && !special_active)
    else $error("special store wrong");

  ovf_sticky_a: assert property (
    overflow && !ovf_skip_op |=> overflow)
    else $error("overflow dropped without skip");

  ovf_set_a: assert property (
    do_add && operand[17] == lower_accumulator_word[17] &&
      arith_sum[17] != operand[17] |=> overflow)
    else $error("add overflow missed");

endmodule : transfer_arith_datapath
`default_nettype wire

/* logic/transfer_arith_pkg.sv */
// constants and carrier types for the transfer and arithmetic datapath
package transfer_arith_pkg;

  localparam int WORD_W = 18;
  localparam int CONST_W = 12;
  localparam int CELL_W = 6;

  typedef logic [WORD_W-1:0] word_t;

  // major function codes, octal
  localparam logic [5:0] F_LOAD_UPPER = 6'o10;
  localparam logic [5:0] F_LOAD_UPPER_B = 6'o11;
  localparam logic [5:0] F_LOAD_LOWER = 6'o12;
  localparam logic [5:0] F_LOAD_LOWER_B = 6'o13;
  localparam logic [5:0] F_ADD_LOWER = 6'o14;
  localparam logic [5:0] F_ADD_LOWER_B = 6'o15;
  localparam logic [5:0] F_SUB_LOWER = 6'o16;
  localparam logic [5:0] F_SUB_LOWER_B = 6'o17;
  localparam logic [5:0] F_LOAD_INDEX = 6'o32;
  localparam logic [5:0] F_LOAD_INDEX_B = 6'o33;
  localparam logic [5:0] F_LOAD_INDEX_CONST = 6'o36;
  localparam logic [5:0] F_ZERO_STORE = 6'o40;
  localparam logic [5:0] F_ZERO_STORE_B = 6'o41;
  localparam logic [5:0] F_STORE_INDEX = 6'o42;
  localparam logic [5:0] F_STORE_INDEX_B = 6'o43;
  localparam logic [5:0] F_STORE_LOWER = 6'o44;
  localparam logic [5:0] F_STORE_LOWER_B = 6'o45;
  localparam logic [5:0] F_STORE_UPPER = 6'o46;
  localparam logic [5:0] F_STORE_UPPER_B = 6'o47;
  localparam logic [5:0] F_MINOR_GROUP = 6'o50;
  localparam logic [5:0] F_LOAD_LOWER_CONST = 6'o70;
  localparam logic [5:0] F_STORE_INDEX_SELECT = 6'o72;
  localparam logic [5:0] F_STORE_ADDR_FIELD = 6'o74;
  localparam logic [5:0] F_STORE_SPECIAL = 6'o75;

  // minor codes under the 50 group
  localparam logic [5:0] M_SKIP_IF_OVERFLOW = 6'o52;
  localparam logic [5:0] M_SKIP_IF_NO_OVERFLOW = 6'o53;
  localparam logic [5:0] M_LOAD_INDEX_SELECT = 6'o72;
  localparam logic [5:0] M_LOAD_SPECIAL = 6'o73;

  // index cell map and field layout
  localparam logic [5:0] CELL_FOR_ZERO = 6'o10;
  localparam int SPECIAL_ACTIVE_BIT = 3;
  localparam int ADDR_FIELD_W = 12;
  localparam int ICR_W = 3;
  localparam int SR_W = 4;
  localparam word_t WORD_RESET = 18'h00000;

  // instruction word as seen by the datapath
  typedef struct packed {
    logic [5:0] func;
    logic [CONST_W-1:0] u;
  } instr_t;

  // one core write request
  typedef struct packed {
    logic en;
    logic to_index_cell;
    logic [CELL_W-1:0] cell_addr;
    word_t data;
  } mem_write_t;

endpackage : transfer_arith_pkg

/* logic/ones_adder.sv */
// 18-bit ones' complement adder with end-around carry and overflow
`timescale 1ns/1ns
`default_nettype none
module ones_adder
  import transfer_arith_pkg::*;
(
  input wire transfer_arith_pkg::word_t a,
  input wire transfer_arith_pkg::word_t b,
  input wire logic subtract,
  output logic [17:0] sum,
  output logic overflow
);
  logic [18:0] raw;
  logic [17:0] b_eff;

  // subtract adds the complement; all ones minus zero stays all ones
  always_comb begin
    b_eff = subtract ? ~b : b;
    raw = {1'b0, a} + {1'b0, b_eff};
    sum = raw[17:0] + {17'h00000, raw[18]};
    overflow = (a[17] == b_eff[17]) && (sum[17] != a[17]);
  end
endmodule : ones_adder
`default_nettype wire

/* sim/core_memory_model.sv */
// core memory model holding operand words and the index cells
`timescale 1ns/1ns
`default_nettype none
module core_memory_model
  import transfer_arith_pkg::*;
(
  input wire logic clk,
  input wire logic issue,
  input wire logic [5:0] eff_addr,
  input wire logic [2:0] index_select_register,
  input wire transfer_arith_pkg::mem_write_t write,
  output transfer_arith_pkg::word_t operand,
  output transfer_arith_pkg::word_t index_word
);
  import transfer_arith_pkg::*;
  word_t mem [0:63];
  logic [5:0] held_addr;
  logic [5:0] b_cell;
  // ********************
  // index cell map
  // ********************
  // select zero lives in cell 10 octal, the rest in cells 1..7
  assign b_cell = (index_select_register == 3'h0) ? 6'h08 : {3'h0, index_select_register};
  assign operand = mem[eff_addr];
  assign index_word = mem[b_cell];
  // write lands a cycle after issue, so the effective address is held
  always @(posedge clk) begin
    if (issue) begin
      held_addr <= eff_addr;
    end
    if (write.en) begin
      if (write.to_index_cell) begin
        mem[write.cell_addr] <= write.data;
      end else begin
        mem[held_addr] <= write.data;
      end
    end
  end
endmodule : core_memory_model
`default_nettype wire

/* sim/transfer_arith_datapath_tb.sv */
// self-checking bench for the transfer and arithmetic datapath
`timescale 1ns/1ns
`default_nettype none
`define check_eq(got, exp) begin check_count++; if ((got) !== (exp)) begin bad_count++; \
  $display("[FAIL] t=%0t got=%h exp=%h", $time, (got), (exp)); end end
module transfer_arith_datapath_tb;
  import transfer_arith_pkg::*;
  typedef struct packed {
    logic [5:0] f;
    logic [11:0] u;
    logic [5:0] ea;
    word_t pre;
    logic [5:0] chk;
    word_t al;
    word_t mem;
  } row_t;
  logic clk;
  logic reset_n;
  logic issue;
  instr_t instr;
  logic [5:0] eff_addr;
  word_t operand;
  word_t index_word;
  mem_write_t write;
  word_t upper_accumulator_word;
  word_t lower_accumulator_word;
  logic [2:0] index_select_register;
  logic [3:0] special_register;
  logic special_active;
  logic overflow;
  logic skip;
  logic done;
  logic skip_seen;
  int bad_count;
  int check_count;
  row_t rows [0:18];
  transfer_arith_datapath dut_u (.clk(clk), .reset_n(reset_n), .issue(issue), .instr(instr),
    .operand(operand), .index_word(index_word), .write(write),
    .upper_accumulator_word(upper_accumulator_word),
    .lower_accumulator_word(lower_accumulator_word),
    .index_select_register(index_select_register), .special_register(special_register),
    .special_active(special_active), .overflow(overflow), .skip(skip), .done(done));
  core_memory_model mem_u (.clk(clk), .issue(issue), .eff_addr(eff_addr),
    .index_select_register(index_select_register), .write(write), .operand(operand),
    .index_word(index_word));
  // ********************
  // clock and closing
  // ********************
  always #5 clk = ~clk;
  task automatic final_report();
    $display("checks %0d mismatches %0d", check_count, bad_count);
    if (bad_count == 0 && check_count > 0) begin
      $display("ALL CHECKS OK");
    end else begin
      $display("CHECKS NOT OK");
    end
    $finish;
  endtask : final_report
  // one instruction: preset the word, pulse issue, look at the answer cycle,
  // then let the memory write land before the next issue reads it
  task automatic run(input logic [5:0] f, input logic [11:0] u, input logic [5:0] ea,
                     input word_t pre);
    mem_u.mem[ea] = pre;
    eff_addr = ea;
    instr = {f, u};
    issue = 1'b1;
    @(posedge clk);
    #1;
    issue = 1'b0;
    skip_seen = skip;
    `check_eq(done, 1'b1)
    @(posedge clk);
    #1;
  endtask : run
  // the run is some 60 cycles; the limit is far above it
  initial begin
    #50000;
    bad_count++;
    final_report();
  end
  initial begin
    // f, u, ea, preset, checked cell, lower acc, checked cell value
    rows = '{
      '{F_LOAD_UPPER, 12'h000, 6'h10, 18'h2aaaa, 6'h10, 18'h00000, 18'h2aaaa},
      '{F_LOAD_LOWER_B, 12'h000, 6'h11, 18'h3ffff, 6'h11, 18'h3ffff, 18'h3ffff},
      '{F_ADD_LOWER, 12'h000, 6'h12, 18'h3ffff, 6'h12, 18'h3ffff, 18'h3ffff},
      '{F_SUB_LOWER_B, 12'h000, 6'h13, 18'h00000, 6'h13, 18'h3ffff, 18'h00000},
      '{F_LOAD_LOWER_CONST, 12'h001, 6'h14, 18'h00000, 6'h14, 18'h00001, 18'h00000},
      '{F_LOAD_LOWER_CONST, 12'hffe, 6'h14, 18'h00000, 6'h14, 18'h3fffe, 18'h00000},
      '{F_STORE_LOWER, 12'h000, 6'h15, 18'h00000, 6'h15, 18'h3fffe, 18'h3fffe},
      '{F_STORE_UPPER_B, 12'h000, 6'h16, 18'h00000, 6'h16, 18'h3fffe, 18'h2aaaa},
      '{F_ZERO_STORE_B, 12'h000, 6'h17, 18'h3ffff, 6'h17, 18'h3fffe, 18'h00000},
      '{F_LOAD_LOWER, 12'h000, 6'h18, 18'h3b544, 6'h18, 18'h3b544, 18'h3b544},
      '{F_STORE_ADDR_FIELD, 12'h000, 6'h19, 18'h2efff, 6'h19, 18'h3b544, 18'h2e544},
      '{F_LOAD_INDEX_CONST, 12'hfc1, 6'h1a, 18'h00000, 6'h08, 18'h3b544, 18'h3ffc1},
      '{F_STORE_INDEX, 12'h000, 6'h1b, 18'h00000, 6'h1b, 18'h3b544, 18'h3ffc1},
      '{F_LOAD_INDEX, 12'h000, 6'h1c, 18'h12345, 6'h08, 18'h3b544, 18'h12345},
      '{F_STORE_INDEX_SELECT, 12'h000, 6'h1d, 18'h00000, 6'h1d, 18'h3b544, 18'h00008},
      '{F_MINOR_GROUP, {M_LOAD_INDEX_SELECT, 6'h3d}, 6'h1e, 18'h0, 6'h1e, 18'h3b544, 18'h0},
      '{F_STORE_INDEX_SELECT, 12'h000, 6'h1f, 18'h3ffff, 6'h1f, 18'h3b544, 18'h3ffc5},
      '{F_MINOR_GROUP, {M_LOAD_SPECIAL, 6'h3b}, 6'h20, 18'h0, 6'h20, 18'h3b544, 18'h0},
      '{F_STORE_SPECIAL, 12'h000, 6'h21, 18'h3ffff, 6'h21, 18'h3b544, 18'h3ffcb}};
    clk = 1'b0;
    reset_n = 1'b0;
    issue = 1'b0;
    instr = '0;
    eff_addr = 6'h00;
    bad_count = 0;
    check_count = 0;
    repeat (2) @(posedge clk);
    #1;
    reset_n = 1'b1;
    `check_eq({lower_accumulator_word, upper_accumulator_word, overflow, write.en}, 38'h0)
    // table pass: loads, stores, constants, partial stores, index cells
    foreach (rows[i]) begin
      run(rows[i].f, rows[i].u, rows[i].ea, rows[i].pre);
      `check_eq(lower_accumulator_word, rows[i].al)
      `check_eq(mem_u.mem[rows[i].chk], rows[i].mem)
    end
    `check_eq(index_select_register, 3'h5)
    `check_eq({special_register, special_active}, 5'h00)
    // special register: bit 3 alone decides active
    run(F_MINOR_GROUP, {M_LOAD_SPECIAL, 6'h38}, 6'h20, 18'h0);
    `check_eq({special_register, special_active}, 5'h11)
    run(F_MINOR_GROUP, {M_LOAD_SPECIAL, 6'h17}, 6'h20, 18'h0);
    `check_eq({special_register, special_active}, 5'h0e)
    // overflow: largest positive plus one turns negative
    run(F_LOAD_LOWER, 12'h000, 6'h22, 18'h1ffff);
    `check_eq(overflow, 1'b0)
    run(F_ADD_LOWER_B, 12'h000, 6'h23, 18'h00001);
    `check_eq({lower_accumulator_word, overflow}, {18'h20000, 1'b1})
    // a load and a store must leave the flag set
    run(F_LOAD_LOWER, 12'h000, 6'h24, 18'h20000);
    run(F_STORE_LOWER, 12'h000, 6'h25, 18'h0);
    `check_eq(overflow, 1'b1)
    run(F_MINOR_GROUP, {M_SKIP_IF_NO_OVERFLOW, 6'h00}, 6'h25, 18'h0);
    `check_eq({skip_seen, overflow}, 2'b00)
    // negative minus positive gives positive: overflow again
    run(F_SUB_LOWER, 12'h000, 6'h26, 18'h00001);
    `check_eq({lower_accumulator_word, overflow}, {18'h1ffff, 1'b1})
    run(F_MINOR_GROUP, {M_SKIP_IF_OVERFLOW, 6'h00}, 6'h26, 18'h0);
    `check_eq({skip_seen, overflow}, 2'b10)
    final_report();
  end
endmodule : transfer_arith_datapath_tb
`default_nettype wire
